// ---- logic/lccd_decoder.sv ----
// design: two-wire slave front end and command decoder with data fifo
`timescale 1ns/10ps
// Overview of operation
// - bits 6:5 = 10 is mode command
// - mux field 01/10/11/00 = 8/16/24/32 rows
// - bits 3:2 of mode give display status
// - bit 4 of mode picks system type
// - bits 6:2 all ones set start bank
// - bits 6:4 = 110 load subaddress counter
// - bits 3:2 of access give access order
// - access order 11 means start bank
// - access low bits load bank selection
// - bit 6 clear loads column pointer
// - sda stable while scl high
// - detect start and stop conditions
// - acknowledge matching address, every command byte and each stored data byte
// - ack held low through clock high
// - release sda after master nack
// - unlimited bytes between start and stop; a data byte that meets a full fifo is not acknowledged
// - msb flags further command bytes
// - commands only in write transfers
// - data only when subaddress matches

// ****************
// fifo
// ****************
module lccd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } lccd_fifo_st_t;
    lccd_fifo_st_t r;
    lccd_fifo_st_t next_r;
    logic          push;
    logic          pop;

    assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (r.cnt != '0);
    assign out_data  = r.mem[r.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wp] = in_data;
            next_r.wp        = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
        end
        if (pop) begin
            next_r.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
        end
        next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule : lccd_fifo

// ****************
// decoder top
// ****************
module lccd_decoder
    import lccd_pkg::*;
#(
    parameter int DEPTH = lccd_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    // two-wire bus pins
    input  wire logic                     scl_in,
    input  wire logic                     sda_in,
    output logic                          sda_out,
    output logic                          sda_oe,
    // straps
    input  wire logic                     addr_lsb,
    input  wire logic [lccd_pkg::SUB_W-1:0] hw_subaddr,
    // command fields
    output logic [lccd_pkg::FLD_W-1:0]    mux_rate,
    output logic [lccd_pkg::FLD_W-1:0]    disp_status,
    output logic                          sys_type,
    output logic [lccd_pkg::BANK_W-1:0]   top_bank,
    output logic [lccd_pkg::SUB_W-1:0]    sub_count,
    output logic [lccd_pkg::FLD_W-1:0]    access_order,
    output logic [lccd_pkg::BANK_W-1:0]   bank_sel,
    output logic [lccd_pkg::COL_W-1:0]    column_ptr,
    // written display data
    output logic [lccd_pkg::CMD_W-1:0]    wr_data,
    output logic                          wr_valid,
    input  wire logic                     wr_ready,
    // read display data
    input  wire logic [lccd_pkg::CMD_W-1:0] rd_data,
    output logic                          rd_strobe
);
    import lccd_pkg::*;

    typedef struct packed {
        logic [2:0]        scl_s;
        logic [2:0]        sda_s;
        lccd_state_t       st;
        lccd_kind_t        kind;
        logic              reading;
        logic [3:0]        bits;
        logic [CMD_W-1:0]  sh;
        logic              drive_low;
        logic              push;
        logic              rd_strobe;
        logic [FLD_W-1:0]  mux_rate;
        logic [FLD_W-1:0]  disp_status;
        logic              sys_type;
        logic [BANK_W-1:0] top_bank;
        logic [SUB_W-1:0]  sub_count;
        logic [FLD_W-1:0]  access_order;
        logic [BANK_W-1:0] bank_sel;
        logic [COL_W-1:0]  column_ptr;
    } lccd_st_t;

    lccd_st_t r;
    lccd_st_t next_r;
    logic     scl_rise;
    logic     scl_fall;
    logic     start_cond;
    logic     stop_cond;
    logic     fifo_ready;
    logic     sub_match;
    logic [CMD_W-1:0] rx_byte;

    // stage 0 feeds only stage 1; edges look at stages 1 and 2
    assign scl_rise   = r.scl_s[1] & ~r.scl_s[2];
    assign scl_fall   = ~r.scl_s[1] & r.scl_s[2];
    assign start_cond = r.scl_s[1] & r.scl_s[2]
                      & ~r.sda_s[1] & r.sda_s[2];
    assign stop_cond  = r.scl_s[1] & r.scl_s[2]
                      & r.sda_s[1] & ~r.sda_s[2];
    assign sub_match  = (r.sub_count == hw_subaddr);
    assign rx_byte    = r.sh;

    always_comb begin
        next_r           = r;
        next_r.scl_s     = {r.scl_s[1:0], scl_in};
        next_r.sda_s     = {r.sda_s[1:0], sda_in};
        next_r.push      = 1'b0;
        next_r.rd_strobe = 1'b0;
        if (start_cond) begin
            // repeated start is accepted from any state
            next_r.st        = LCCD_RX;
            next_r.kind      = LCCD_K_ADDR;
            next_r.bits      = BIT_ZERO;
            next_r.drive_low = 1'b0;
        end else if (stop_cond) begin
            next_r.st        = LCCD_IDLE;
            next_r.drive_low = 1'b0;
        end else begin
            case (r.st)
                LCCD_RX: begin
                    if (scl_rise && r.bits != BIT_LAST) begin
                        next_r.sh   = {r.sh[CMD_W-2:0], r.sda_s[1]};
                        next_r.bits = r.bits + BIT_ONE;
                    end else if (scl_fall && r.bits == BIT_LAST) begin
                        next_r.st = LCCD_ACK;
                        case (r.kind)
                            LCCD_K_ADDR: begin
                                if (rx_byte[CMD_W-1:1]
                                        == {SLAVE_ADDR_HI, addr_lsb}) begin
                                    next_r.drive_low = 1'b1;
                                    next_r.reading   = rx_byte[0];
                                end else begin
                                    next_r.st = LCCD_IDLE;
                                end
                            end
                            LCCD_K_CMD: begin
                                next_r.drive_low = 1'b1;
                                if (!rx_byte[CONT_BIT]) begin
                                    next_r.kind = LCCD_K_DATA;
                                end
                                if (!rx_byte[SEL_BIT]) begin
                                    next_r.column_ptr =
                                        rx_byte[COL_W-1:0];
                                end else if (!rx_byte[KIND_BIT]) begin
                                    next_r.mux_rate    =
                                        rx_byte[FLD_W-1:0];
                                    next_r.disp_status =
                                        rx_byte[STAT_HI:STAT_LO];
                                    next_r.sys_type    =
                                        rx_byte[TYPE_BIT];
                                end else if (!rx_byte[GRP_BIT]) begin
                                    next_r.sub_count =
                                        rx_byte[SUB_W-1:0];
                                end else if (rx_byte[ORDER_HI:ORDER_LO]
                                        == ORDER_BANKCMD) begin
                                    next_r.top_bank =
                                        rx_byte[BANK_W-1:0];
                                end else begin
                                    next_r.access_order =
                                        rx_byte[ORDER_HI:ORDER_LO];
                                    next_r.bank_sel =
                                        rx_byte[BANK_W-1:0];
                                end
                            end
                            default: begin
                                // full fifo withholds the ack
                                if (sub_match && fifo_ready) begin
                                    next_r.drive_low = 1'b1;
                                    next_r.push      = 1'b1;
                                end else begin
                                    next_r.st = LCCD_IDLE;
                                end
                            end
                        endcase
                    end
                end
                LCCD_ACK: begin
                    if (scl_fall) begin
                        next_r.drive_low = 1'b0;
                        next_r.bits      = BIT_ZERO;
                        if (r.kind == LCCD_K_ADDR) begin
                            next_r.kind = LCCD_K_CMD;
                        end
                        if (r.kind == LCCD_K_ADDR && r.reading) begin
                            next_r.kind      = LCCD_K_DATA;
                            next_r.st        = LCCD_TX;
                            next_r.sh        = rd_data;
                            next_r.rd_strobe = 1'b1;
                            next_r.drive_low = ~rd_data[CMD_W-1]
                                             & sub_match;
                        end else begin
                            next_r.st = LCCD_RX;
                        end
                    end
                end
                LCCD_TX: begin
                    if (scl_fall) begin
                        next_r.bits = r.bits + BIT_ONE;
                        next_r.sh   = {r.sh[CMD_W-2:0], 1'b0};
                        if (r.bits == BIT_LAST - BIT_ONE) begin
                            next_r.drive_low = 1'b0;
                            next_r.st        = LCCD_RACK;
                        end else begin
                            next_r.drive_low = ~r.sh[CMD_W-2] & sub_match;
                        end
                    end
                end
                LCCD_RACK: begin
                    if (scl_rise && r.sda_s[1]) begin
                        next_r.st = LCCD_IDLE;
                    end else if (scl_fall) begin
                        next_r.st        = LCCD_TX;
                        next_r.bits      = BIT_ZERO;
                        next_r.sh        = rd_data;
                        next_r.rd_strobe = 1'b1;
                        next_r.drive_low = ~rd_data[CMD_W-1] & sub_match;
                    end
                end
                default: begin
                    next_r.drive_low = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r              <= '0;
            // idle bus level, so no false start after reset
            r.scl_s        <= '1;
            r.sda_s        <= '1;
            r.st           <= LCCD_IDLE;
            r.kind         <= LCCD_K_ADDR;
            r.mux_rate     <= MUX_RST;
            r.disp_status  <= STATUS_BLANK;
            r.top_bank     <= FLD_RST;
            r.sub_count    <= SUB_RST;
            r.access_order <= FLD_RST;
            r.bank_sel     <= FLD_RST;
            r.column_ptr   <= COL_RST;
            r.sh           <= BYTE_RST;
        end else begin
            r <= next_r;
        end
    end

    lccd_fifo #(
        .WIDTH (CMD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_data   (r.sh),
        .in_valid  (r.push),
        .in_ready  (fifo_ready),
        .out_data  (wr_data),
        .out_valid (wr_valid),
        .out_ready (wr_ready)
    );

    assign sda_out      = 1'b0;
    assign sda_oe       = r.drive_low;
    assign rd_strobe    = r.rd_strobe;
    assign mux_rate     = r.mux_rate;
    assign disp_status  = r.disp_status;
    assign sys_type     = r.sys_type;
    assign top_bank     = r.top_bank;
    assign sub_count    = r.sub_count;
    assign access_order = r.access_order;
    assign bank_sel     = r.bank_sel;
    assign column_ptr   = r.column_ptr;

    // ****************
    // checks
    // ****************
    a_stop_idle: assert property (@(posedge sys_clk) disable iff (rst)
        stop_cond |=> (r.st == LCCD_IDLE) && !sda_oe)
        else $error("stop did not release the bus");
    a_start_rx: assert property (@(posedge sys_clk) disable iff (rst)
        start_cond |=> (r.st == LCCD_RX) && (r.bits == BIT_ZERO))
        else $error("start did not open address byte");
    a_ack_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (r.st == LCCD_ACK) && sda_oe && !scl_fall && !start_cond
            && !stop_cond |=> sda_oe)
        else $error("ack dropped before clock fall");
    a_col_load: assert property (@(posedge sys_clk) disable iff (rst)
        (r.st == LCCD_RX) && scl_fall && (r.bits == BIT_LAST)
            && (r.kind == LCCD_K_CMD) && !r.sh[SEL_BIT] && !stop_cond
            && !start_cond |=> column_ptr == $past(r.sh[COL_W-1:0]))
        else $error("column pointer not loaded");
    a_mode_load: assert property (@(posedge sys_clk) disable iff (rst)
        (r.st == LCCD_RX) && scl_fall && (r.bits == BIT_LAST)
            && (r.kind == LCCD_K_CMD) && (r.sh[6:5] == 2'h2)
            && !stop_cond && !start_cond
            |=> mux_rate == $past(r.sh[1:0])
            && disp_status == $past(r.sh[3:2]))
        else $error("mode fields not loaded");
    a_bank_cmd: assert property (@(posedge sys_clk) disable iff (rst)
        (r.st == LCCD_RX) && scl_fall && (r.bits == BIT_LAST)
            && (r.kind == LCCD_K_CMD) && (r.sh[6:2] == 5'h1F)
            && !stop_cond && !start_cond
            |=> $stable(access_order) && top_bank == $past(r.sh[1:0]))
        else $error("code 11 taken as access command");
    a_data_match: assert property (@(posedge sys_clk) disable iff (rst)
        r.push |-> sub_match)
        else $error("data stored without subaddress match");
    a_nack_release: assert property (@(posedge sys_clk)
        disable iff (rst)
        (r.st == LCCD_RACK) && scl_rise && r.sda_s[1] && !stop_cond
            && !start_cond |=> !sda_oe [*2])
        else $error("line held after master nack");
    a_reset_blank: assert property (@(posedge sys_clk)
        rst |=> disp_status == STATUS_BLANK && column_ptr == COL_RST)
        else $error("reset did not blank display");
endmodule : lccd_decoder

// ---- logic/lccd_pkg.sv ----
// package: constants of the lcd column command decoder
package lccd_pkg;
    // ****************
    // command fields
    // ****************
    localparam int CMD_W         = 8;
    localparam int CONT_BIT      = 7;
    localparam int SEL_BIT       = 6;
    localparam int KIND_BIT      = 5;
    localparam int GRP_BIT       = 4;
    localparam int TYPE_BIT      = 4;
    localparam int STAT_HI       = 3;
    localparam int STAT_LO       = 2;
    localparam int ORDER_HI      = 3;
    localparam int ORDER_LO      = 2;
    localparam int COL_W         = 6;
    localparam int SUB_W         = 4;
    localparam int BANK_W        = 2;
    localparam int FLD_W         = 2;
    localparam logic [1:0] ORDER_BANKCMD = 2'h3;
    // ****************
    // bus protocol
    // ****************
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h1E;
    localparam logic [3:0] BIT_LAST      = 4'h8;
    localparam logic [3:0] BIT_ZERO      = 4'h0;
    localparam logic [3:0] BIT_ONE       = 4'h1;
    // ****************
    // reset values and fifo depth
    // ****************
    localparam logic [1:0] MUX_RST       = 2'h0;
    localparam logic [1:0] STATUS_BLANK  = 2'h0;
    localparam logic [1:0] FLD_RST       = 2'h0;
    localparam logic [3:0] SUB_RST       = 4'h0;
    localparam logic [5:0] COL_RST       = 6'h00;
    localparam logic [7:0] BYTE_RST      = 8'h00;
    localparam int FIFO_DEPTH    = 4;
    // ****************
    // types
    // ****************
    typedef enum logic [2:0] {
        LCCD_IDLE, LCCD_RX, LCCD_ACK, LCCD_TX, LCCD_RACK
    } lccd_state_t;
    typedef enum logic [1:0] {
        LCCD_K_ADDR, LCCD_K_CMD, LCCD_K_DATA
    } lccd_kind_t;
endpackage : lccd_pkg

// ---- tb/lccd_bus_master.sv ----
// bench: two-wire bus master model driving the decoder's pins
`timescale 1ns/10ps
module lccd_bus_master (
    // clock
    input  wire logic sys_clk,
    // bus pins
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // ****************
    // timing
    // ****************
    // a quarter of the 160 ns bus period, in system clocks
    localparam int QTR = 2;

    task automatic qwait(input int n);
        repeat (n * QTR) @(negedge sys_clk);
    endtask : qwait

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // ****************
    // conditions
    // ****************
    // called only with both lines high
    task automatic start_c();
        qwait(1);
        sda_low = 1'b1;
        qwait(2);
        scl = 1'b0;
    endtask : start_c

    task automatic stop_c();
        qwait(1);
        sda_low = 1'b1;
        qwait(1);
        scl = 1'b1;
        qwait(2);
        sda_low = 1'b0;
        qwait(4);
    endtask : stop_c

    // ****************
    // bits and bytes
    // ****************
    // data changes mid-low only, so it never moves while scl is high
    task automatic clk_bit(input logic b, output logic s);
        qwait(1);
        sda_low = ~b;
        qwait(1);
        scl = 1'b1;
        qwait(1);
        s = sda;
        qwait(1);
        scl = 1'b0;
    endtask : clk_bit

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], s);
        end
        clk_bit(1'b1, s);
        ack = (s === 1'b0);
    endtask : write_byte

    // the last byte is left unacknowledged
    task automatic read_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, d[i]);
        end
        clk_bit(~mack, s);
    endtask : read_byte
endmodule : lccd_bus_master

// ---- tb/test_lcd_column_cmd_decoder.sv ----
// bench: self-checking testbench of the command decoder
`timescale 1ns/10ps
module test_lcd_column_cmd_decoder;
    import lccd_pkg::*;
    logic       sys_clk, rst, scl, sda_low, sda_line, sda_out, sda_oe;
    logic       addr_lsb, sys_type, wr_valid, wr_ready, rd_strobe, ack;
    logic [3:0] hw_subaddr, sub_count;
    logic [1:0] mux_rate, disp_status, top_bank, access_order, bank_sel;
    logic [5:0] column_ptr;
    logic [7:0] wr_data, rd_data, d;
    int         n_mismatch, cmp_count, n_rd;

    // pull-up: low only while some party pulls
    assign sda_line = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

    lccd_bus_master bus_u (.sys_clk(sys_clk), .scl(scl), .sda_low(sda_low),
        .sda(sda_line));
    lccd_decoder dut_u (.sys_clk(sys_clk), .rst(rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_lsb(addr_lsb), .hw_subaddr(hw_subaddr), .mux_rate(mux_rate),
        .disp_status(disp_status), .sys_type(sys_type),
        .top_bank(top_bank), .sub_count(sub_count),
        .access_order(access_order), .bank_sel(bank_sel),
        .column_ptr(column_ptr), .wr_data(wr_data), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .rd_data(rd_data), .rd_strobe(rd_strobe));

    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (rd_strobe === 1'b1) n_rd++;

    // ****************
    // helpers
    // ****************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic addr(input logic rw);
        bus_u.start_c();
        bus_u.write_byte({SLAVE_ADDR_HI, 1'b1, rw}, ack);
        check(8'(ack), 8'h01);
    endtask : addr

    task automatic cmd(input logic [7:0] b);
        bus_u.write_byte(b, ack);
        check(8'(ack), 8'h01);
    endtask : cmd

    // ****************
    // scenarios
    // ****************
    task automatic t_reset();
        check({mux_rate, disp_status, top_bank, access_order}, 8'h00);
        check({sub_count, bank_sel, sys_type, sda_oe}, 8'h00);
        check({column_ptr, wr_valid, rd_strobe}, 8'h00);
        $display("reset test done");
    endtask : t_reset

    task automatic t_mode();
        addr(1'b0);
        for (int i = 0; i < 4; i++) begin
            cmd({3'b110, i[0], i[1:0], 2'(3 - i)});
            check(8'(mux_rate), 8'(3 - i));
            check(8'(disp_status), 8'(i));
            check(8'(sys_type), 8'(i[0]));
        end
        bus_u.stop_c();
        $display("mode test done");
    endtask : t_mode

    task automatic t_bank();
        addr(1'b0);
        for (int b = 0; b < 4; b++) begin
            cmd({6'h3F, 2'(b)});
            check(8'(top_bank), 8'(b));
        end
        for (int g = 0; g < 3; g++) begin
            cmd({4'hF, 2'(g), 2'(3 - g)});
            check(8'(access_order), 8'(g));
            check(8'(bank_sel), 8'(3 - g));
        end
        cmd(8'hFE);
        check({2'b00, top_bank, access_order, bank_sel}, 8'h29);
        bus_u.stop_c();
        $display("bank test done");
    endtask : t_bank

    task automatic t_data();
        addr(1'b0);
        cmd(8'hEF);
        check(8'(sub_count), 8'h0F);
        cmd(8'hA7);
        check(8'(column_ptr), 8'h27);
        cmd(8'h80);
        check(8'(column_ptr), 8'h00);
        cmd(8'hEA);
        cmd(8'h27);
        for (int i = 0; i < 5; i++) begin
            bus_u.write_byte(8'hF0 + 8'(i), ack);
            check(8'(ack), (i < 4) ? 8'h01 : 8'h00);
        end
        check(8'(column_ptr), 8'h27);
        check({4'h0, access_order, bank_sel}, 8'h09);
        bus_u.stop_c();
        for (int i = 0; i < 4; i++) begin
            check({7'h00, wr_valid}, 8'h01);
            check(wr_data, 8'hF0 + 8'(i));
            wr_ready = 1'b1;
            @(negedge sys_clk);
            wr_ready = 1'b0;
            @(negedge sys_clk);
        end
        check(8'(wr_valid), 8'h00);
        $display("data test done");
    endtask : t_data

    task automatic t_refuse();
        addr(1'b0);
        cmd(8'hE5);
        cmd(8'h05);
        bus_u.write_byte(8'h11, ack);
        check({ack, wr_valid, column_ptr}, 8'h05);
        bus_u.stop_c();
        bus_u.start_c();
        bus_u.write_byte({SLAVE_ADDR_HI, 2'b00}, ack);
        check(8'(ack), 8'h00);
        bus_u.stop_c();
        $display("refuse test done");
    endtask : t_refuse

    task automatic t_read();
        addr(1'b0);
        cmd(8'h6A);
        bus_u.stop_c();
        n_rd = 0;
        rd_data = 8'hA5;
        addr(1'b1);
        bus_u.read_byte(1'b1, d);
        rd_data = 8'h3C;
        check(d, 8'hA5);
        bus_u.read_byte(1'b0, d);
        check(d, 8'h3C);
        bus_u.qwait(2);
        check({sda_oe, 7'(n_rd)}, 8'h02);
        bus_u.stop_c();
        $display("read test done");
    endtask : t_read

    // ****************
    // run control
    // ****************
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    // whole run is about 2.7k clocks; allow nearly four times that
    initial begin
        #200000;
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        addr_lsb = 1'b1;
        hw_subaddr = 4'hA;
        wr_ready = 1'b0;
        rd_data = 8'h00;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        t_reset();
        t_mode();
        t_bank();
        t_data();
        t_refuse();
        t_read();
        close_out();
    end
endmodule : test_lcd_column_cmd_decoder
